// file: design/accel_fifo_map.svh
// Register map, field positions, reset values and sizes of the sample buffer.
// Assumes the serial port front end decodes byte addresses into strobes.
`ifndef ACCEL_FIFO_MAP_SVH
`define ACCEL_FIFO_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define AXIS_X_LO_ADDR 8'h32
`define AXIS_Z_HI_ADDR 8'h37
`define BUF_CTL_ADDR 8'h38
`define BUF_STATUS_ADDR 8'h39

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define CTL_MODE_HI 7
`define CTL_MODE_LO 6
`define CTL_TRIG_SEL 5
`define CTL_DEPTH_HI 4
`define CTL_DEPTH_LO 0
`define CTL_RESET 8'h00
`define STAT_TRIG_BIT 7

// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define BUF_DEPTH 32
`define SAMPLE_BYTES 6

`endif

// file: design/accel_fifo_pkg.sv
// Types shared by the sample buffer and its surroundings.
// Assumes nothing outside; offsets live in accel_fifo_map.svh.
package accel_fifo_pkg;

    typedef struct packed {
        logic [15:0] z;
        logic [15:0] y;
        logic [15:0] x;
    } sample_t;

    // One decoded byte access from the serial port front end
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic xfer_end;
    } reg_req_t;

    typedef enum logic [1:0] {
        MODE_BYPASS = 2'b00,
        MODE_FILL = 2'b01,
        MODE_ROLL = 2'b10,
        MODE_TRIG = 2'b11
    } policy_t;

    typedef enum logic [1:0] {
        CAP_PRE = 2'b01,
        CAP_POST = 2'b10
    } cap_state_t;

endpackage : accel_fifo_pkg

// file: design/sample_fifo.sv
// Synchronous FIFO with valid/ready on both sides and an occupancy count.
// Assumes one clock; push and pop may share a cycle, also when full.
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i,
    // Occupancy
    output logic [AW:0] count_o
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic full;
    logic push;
    logic pop;

    assign full = (count_reg == (AW + 1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    // A full buffer still takes a word when the head leaves in the same cycle
    assign in_ready_o = !full || out_ready_i;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_reg];
    assign count_o = count_reg;

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end

endmodule : sample_fifo

// file: design/accel_sample_fifo.sv
// Acceleration sample buffer: four buffering policies, trigger capture,
// watermark and overrun flags, status and control registers.
// Assumes the serial port front end delivers decoded byte accesses on the
// same clock and marks the end of each transfer with xfer_end.
`timescale 1ns/1ps
`include "accel_fifo_map.svh"
module accel_sample_fifo #(
    parameter int DEPTH = `BUF_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Sample source
    input wire logic sample_valid_i,
    input wire accel_fifo_pkg::sample_t sample_i,
    input wire logic sleep_i,
    // Trigger events as routed to the two interrupt lines
    input wire logic irq_line_a_event_i,
    input wire logic irq_line_b_event_i,
    // Register port
    input wire accel_fifo_pkg::reg_req_t reg_req_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    // Presented sample
    output logic [15:0] axis_x_out_o,
    output logic [15:0] axis_y_out_o,
    output logic [15:0] axis_z_out_o,
    // Event flags
    output logic data_ready_o,
    output logic watermark_o,
    output logic overrun_o,
    output logic capture_event_flag_o
);

    localparam int CW = $clog2(DEPTH) + 1;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] ctl_reg;
    accel_fifo_pkg::policy_t mode;
    logic trig_sel;
    logic [CW-1:0] depth;
    accel_fifo_pkg::cap_state_t cap_reg;
    accel_fifo_pkg::sample_t out_reg;
    logic out_valid_reg;
    logic touched_reg;
    logic ovr_reg;
    logic wm_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;

    logic smp_take;
    logic ctl_wr;
    logic data_hit;
    logic pop_now;
    logic trig_ev;
    logic full;
    logic pre_trig;
    logic drop_head;
    logic load_out;
    logic ovr_ev;
    logic wm_cond;
    logic bypass_on;
    logic roll_on;
    logic watch_level;
    logic fill_drop;
    logic roll_drop;
    logic bypass_drop;
    logic [7:0] status_byte;
    logic [7:0] rd_byte;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    accel_fifo_pkg::sample_t fifo_out_data;
    logic [CW-1:0] count;
    logic [7:0] out_bytes [`SAMPLE_BYTES];

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    assign mode = accel_fifo_pkg::policy_t'(ctl_reg[`CTL_MODE_HI:`CTL_MODE_LO]);
    assign trig_sel = ctl_reg[`CTL_TRIG_SEL];
    assign depth = CW'(ctl_reg[`CTL_DEPTH_HI:`CTL_DEPTH_LO]);

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    assign ctl_wr = reg_req_i.wr && (reg_req_i.addr == `BUF_CTL_ADDR);
    assign data_hit = reg_req_i.rd
        && (reg_req_i.addr >= `AXIS_X_LO_ADDR)
        && (reg_req_i.addr <= `AXIS_Z_HI_ADDR);

    // The pop waits for the end of the transfer so a burst sees one sample
    assign pop_now = reg_req_i.xfer_end && (touched_reg || data_hit);

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            touched_reg <= 1'b0;
        end else if (reg_req_i.xfer_end) begin
            touched_reg <= 1'b0;
        end else if (data_hit) begin
            touched_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl_reg <= `CTL_RESET;
        end else if (ctl_wr) begin
            ctl_reg <= reg_req_i.wdata;
        end
    end

    // ------------------------------------------------------------
    // Trigger capture
    // ------------------------------------------------------------
    assign trig_ev = trig_sel ? irq_line_b_event_i : irq_line_a_event_i;

    // Rewriting control rearms the capture
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cap_reg <= accel_fifo_pkg::CAP_PRE;
        end else begin
            case (cap_reg)
                accel_fifo_pkg::CAP_PRE: begin
                    if (!ctl_wr && trig_ev && mode == accel_fifo_pkg::MODE_TRIG) begin
                        cap_reg <= accel_fifo_pkg::CAP_POST;
                    end
                end
                accel_fifo_pkg::CAP_POST: begin
                    if (ctl_wr) begin
                        cap_reg <= accel_fifo_pkg::CAP_PRE;
                    end
                end
                default: begin
                    cap_reg <= accel_fifo_pkg::CAP_PRE;
                end
            endcase
        end
    end

    assign pre_trig = (mode == accel_fifo_pkg::MODE_TRIG)
        && (cap_reg == accel_fifo_pkg::CAP_PRE);

    // ------------------------------------------------------------
    // Policy decode
    // ------------------------------------------------------------
    // Depth is a watermark level in fill-and-stop and rolling; a zero depth raises the watermark in every mode
    always_comb begin
        bypass_on = 1'b0;
        roll_on = 1'b0;
        watch_level = 1'b0;
        case (mode)
            accel_fifo_pkg::MODE_BYPASS: begin
                bypass_on = 1'b1;
            end
            accel_fifo_pkg::MODE_FILL: begin
                watch_level = 1'b1;
            end
            accel_fifo_pkg::MODE_ROLL: begin
                roll_on = 1'b1;
                watch_level = 1'b1;
            end
            default: begin
                watch_level = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Buffering policy
    // ------------------------------------------------------------
    assign smp_take = sample_valid_i && !sleep_i;
    assign full = (count == CW'(DEPTH));
    assign load_out = !out_valid_reg && fifo_out_valid
        && (mode != accel_fifo_pkg::MODE_BYPASS);

    // Head is discarded to make room: rolling at full, or pre-trigger at depth
    always_comb begin
        drop_head = 1'b0;
        if (smp_take && !load_out) begin
            if (roll_on && full) begin
                drop_head = 1'b1;
            end else if (pre_trig && count >= depth && count != '0) begin
                drop_head = 1'b1;
            end
        end
    end

    assign fifo_in_valid = smp_take && (mode != accel_fifo_pkg::MODE_BYPASS);
    assign fifo_out_ready = load_out || drop_head;

    // ------------------------------------------------------------
    // Overrun causes
    // ------------------------------------------------------------
    // Fill-and-stop and post-trigger are refused by in_ready when full
    assign fill_drop = fifo_in_valid && !fifo_in_ready;
    // Rolling at full loses its oldest entry to make room
    assign roll_drop = roll_on && drop_head;
    // Bypass overwrites an output stage that the host has not read yet
    assign bypass_drop = bypass_on && smp_take && out_valid_reg;

    always_comb begin
        ovr_ev = 1'b0;
        if (fill_drop || roll_drop || bypass_drop) begin
            ovr_ev = 1'b1;
        end
    end

    sample_fifo #(
        .WIDTH($bits(accel_fifo_pkg::sample_t)),
        .DEPTH(DEPTH)
    ) i_sample_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(fifo_in_valid),
        .in_data_i(sample_i),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out_data),
        .out_ready_i(fifo_out_ready),
        .count_o(count)
    );

    // ------------------------------------------------------------
    // Output stage: the extra entry beyond the buffer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_reg <= '0;
        end else if (load_out) begin
            out_reg <= fifo_out_data;
        end else if (mode == accel_fifo_pkg::MODE_BYPASS && smp_take) begin
            out_reg <= sample_i;
        end
    end

    // In bypass, a new sample in the cycle of a pop keeps data ready set
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_valid_reg <= 1'b0;
        end else if (load_out) begin
            out_valid_reg <= 1'b1;
        end else if (mode == accel_fifo_pkg::MODE_BYPASS && smp_take) begin
            out_valid_reg <= 1'b1;
        end else if (pop_now) begin
            out_valid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------
    always_comb begin
        wm_cond = 1'b0;
        if (depth == '0) begin
            wm_cond = 1'b1;
        end else if (watch_level) begin
            wm_cond = (count >= depth);
        end
    end

    // Level follows occupancy, so draining through data reads clears it
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wm_reg <= 1'b0;
        end else begin
            wm_reg <= wm_cond;
        end
    end

    // Set wins over the clear from a pop in the same cycle
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ovr_reg <= 1'b0;
        end else if (ovr_ev) begin
            ovr_reg <= 1'b1;
        end else if (pop_now) begin
            ovr_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `SAMPLE_BYTES; gi++) begin : g_bytes
            assign out_bytes[gi] = out_reg[gi*8 +: 8];
        end
    endgenerate

    // ------------------------------------------------------------
    // Status byte
    // ------------------------------------------------------------
    // Bit 6 is reserved; the output stage is not part of the count
    always_comb begin
        status_byte = 8'h00;
        status_byte[`STAT_TRIG_BIT] = (cap_reg == accel_fifo_pkg::CAP_POST);
        status_byte[5:0] = 6'(count);
    end

    // Unmapped addresses read as zero
    always_comb begin
        rd_byte = 8'h00;
        if (data_hit) begin
            rd_byte = out_bytes[3'(reg_req_i.addr - `AXIS_X_LO_ADDR)];
        end else if (reg_req_i.addr == `BUF_CTL_ADDR) begin
            rd_byte = ctl_reg;
        end else if (reg_req_i.addr == `BUF_STATUS_ADDR) begin
            rd_byte = status_byte;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_reg <= 8'h00;
        end else if (reg_req_i.rd) begin
            rd_data_reg <= rd_byte;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= reg_req_i.rd;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
    assign axis_x_out_o = out_reg.x;
    assign axis_y_out_o = out_reg.y;
    assign axis_z_out_o = out_reg.z;
    assign data_ready_o = out_valid_reg;
    assign watermark_o = wm_reg;
    assign overrun_o = ovr_reg;
    assign capture_event_flag_o = (cap_reg == accel_fifo_pkg::CAP_POST);

endmodule : accel_sample_fifo

// file: verification/accel_fifo_monitor.sv
// Port checks for the sample buffer.
// Assumes a bind from the bench top; one clock, async active-low reset.
`timescale 1ns/1ps
module accel_fifo_monitor (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Inputs
    input wire logic sample_valid_i,
    input wire logic irq_line_a_event_i,
    input wire logic irq_line_b_event_i,
    input wire accel_fifo_pkg::reg_req_t reg_req_i,
    // Outputs
    input wire logic [7:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic [15:0] axis_x_out_o,
    input wire logic [15:0] axis_z_out_o,
    input wire logic data_ready_o,
    input wire logic watermark_o,
    input wire logic overrun_o,
    input wire logic capture_event_flag_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // ------
    // Sequences
    // ------
    sequence s_rd(a);
        reg_req_i.rd && reg_req_i.addr == a;
    endsequence
    // Data byte read that closes the transfer: the pop point
    sequence s_pop;
        reg_req_i.rd && reg_req_i.xfer_end && reg_req_i.addr inside {[8'h32:8'h37]};
    endsequence
    sequence s_depth_zero;
        reg_req_i.wr && reg_req_i.addr == 8'h38 ##0 reg_req_i.wdata[4:0] == 5'h00;
    endsequence

    a_rd_answered: assert property (reg_req_i.rd |=> rd_valid_o)
        else $error("read byte not answered");
    a_x_low: assert property (
        s_rd(8'h32) |=> rd_data_o == $past(axis_x_out_o[7:0]))
        else $error("x low byte wrong");
    a_z_high: assert property (
        s_rd(8'h37) |=> rd_data_o == $past(axis_z_out_o[15:8]))
        else $error("z high byte wrong");
    a_status_byte: assert property (s_rd(8'h39) |=>
        rd_data_o[7] == $past(capture_event_flag_o) && !rd_data_o[6] && rd_data_o[5:0] <= 6'd32)
        else $error("status byte wrong");
    a_pop_output: assert property (
        s_pop ##0 data_ready_o && !sample_valid_i |=> !data_ready_o)
        else $error("output stage not popped");
    a_depth_zero: assert property (s_depth_zero |-> ##[1:2] watermark_o)
        else $error("zero depth did not raise watermark");
    a_overrun_sticky: assert property (
        overrun_o && !reg_req_i.xfer_end && !$past(reg_req_i.xfer_end) |=> overrun_o)
        else $error("overrun cleared without data read");
    a_overrun_cause: assert property (
        $rose(overrun_o) |-> $past(sample_valid_i) || $past(sample_valid_i, 2))
        else $error("overrun without sample");
    a_capture_cause: assert property ($rose(capture_event_flag_o) |->
        $past(irq_line_a_event_i) || $past(irq_line_b_event_i))
        else $error("capture flag without event");
    a_capture_hold: assert property (
        capture_event_flag_o && !(reg_req_i.wr && reg_req_i.addr == 8'h38)
        |=> capture_event_flag_o)
        else $error("capture flag dropped");
endmodule : accel_fifo_monitor

// file: verification/host_port_model.sv
// Host on the register port: one byte per clock, bursts for samples.
// Assumes callers enter just after a rising edge.
`timescale 1ns/1ps
module host_port_model (
    // Clock
    input wire logic ref_clk_i,
    // Register port
    output accel_fifo_pkg::reg_req_t reg_req_o,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i
);
    initial reg_req_o = '0;

    // A missing answer comes back unknown, so the caller's compare fails
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                        input logic last, output logic [7:0] rdata);
        reg_req_o = '{rd: !wr, wr: wr, addr: addr, wdata: wd, xfer_end: last};
        @(posedge ref_clk_i);
        #1;
        rdata = (wr || rd_valid_i === 1'b1) ? rd_data_i : 8'hxx;
    endtask : xfer

    // Two idle edges let the pop land before the next transfer
    task automatic idle();
        reg_req_o = '0;
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask : idle

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        xfer(1'b1, addr, data, 1'b1, unused);
        idle();
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        xfer(1'b0, addr, 8'h00, 1'b1, data);
        idle();
    endtask : read_reg

    task automatic read_sample(output accel_fifo_pkg::sample_t s);
        logic [7:0] b [6];
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, 8'h32 + 8'(i), 8'h00, i == 5, b[i]);
        end
        idle();
        s = {b[5], b[4], b[3], b[2], b[1], b[0]};
    endtask : read_sample
endmodule : host_port_model

// file: verification/accel_sample_fifo_tb.sv
// Bench for the sample buffer: policies, flags, status and drain order.
// Assumes the host model drives the register port; samples come from here.
`timescale 1ns/1ps
module accel_sample_fifo_tb;
    logic ref_clk_i, rst_b_i, sample_valid_i, sleep_i, irq_a, irq_b;
    logic rd_valid, data_ready, watermark, overrun, capture;
    logic [7:0] rd_data, d;
    logic [15:0] ax, ay, az;
    accel_fifo_pkg::sample_t sample_i, got;
    accel_fifo_pkg::reg_req_t reg_req;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int expq[$];

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    accel_sample_fifo i_accel_sample_fifo (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .sample_valid_i(sample_valid_i), .sample_i(sample_i), .sleep_i(sleep_i),
        .irq_line_a_event_i(irq_a), .irq_line_b_event_i(irq_b),
        .reg_req_i(reg_req), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .axis_x_out_o(ax), .axis_y_out_o(ay), .axis_z_out_o(az),
        .data_ready_o(data_ready), .watermark_o(watermark), .overrun_o(overrun),
        .capture_event_flag_o(capture)
    );
    host_port_model i_host_port_model (
        .ref_clk_i(ref_clk_i), .reg_req_o(reg_req), .rd_data_i(rd_data), .rd_valid_i(rd_valid)
    );

    // ------
    // Helpers
    // ------
    function automatic accel_fifo_pkg::sample_t mk(input int id);
        return '{z: 16'(id) ^ 16'h5a00, y: ~16'(id), x: 16'(id)};
    endfunction : mk

    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t %s: got %h exp %h", $time, what, g, e);
        end
    endtask : chk

    // Spaced pushes give the output stage time to load between samples
    task automatic push_run(input int first, input int n);
        for (int i = first; i < first + n; i++) begin
            sample_i = mk(i);
            sample_valid_i = 1'b1;
            @(posedge ref_clk_i);
            #1;
            sample_valid_i = 1'b0;
            @(posedge ref_clk_i);
            #1;
        end
    endtask : push_run

    task automatic drain(input int n);
        accel_fifo_pkg::sample_t e;
        repeat (n) begin
            i_host_port_model.read_sample(got);
            e = mk(expq.pop_front());
            chk(got.x, e.x, "x axis");
            chk(got.y, e.y, "y axis");
            chk(got.z, e.z, "z axis");
        end
    endtask : drain

    task automatic status(input logic [7:0] e, input string what);
        i_host_port_model.read_reg(8'h39, d);
        chk(16'(d), 16'(e), what);
    endtask : status

    task automatic pulse(input logic line_b);
        irq_a = !line_b;
        irq_b = line_b;
        @(posedge ref_clk_i);
        #1;
        irq_a = 1'b0;
        irq_b = 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask : pulse

    task automatic results();
        $display("Counts: %0d checks, %0d mismatches", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("MISMATCH t=%0t run did not finish", $time);
            results();
        end
    end

    initial begin
        rst_b_i = 1'b0;
        sample_valid_i = 1'b0;
        sleep_i = 1'b0;
        irq_a = 1'b0;
        irq_b = 1'b0;
        sample_i = '0;
        repeat (16) @(posedge ref_clk_i);
        #1;
        rst_b_i = 1'b1;
        status(8'h00, "status at reset");
        i_host_port_model.read_reg(8'h10, d);
        chk(16'(d), 16'h0000, "unmapped read");
        chk(16'(watermark), 16'h0001, "zero depth watermark");
        i_host_port_model.write_reg(8'h39, 8'hff);
        status(8'h00, "status read-only");
        $display("test reset done");
        push_run(1, 2);
        status(8'h00, "bypass stores nothing");
        chk(ax, 16'h0002, "bypass newest");
        chk(ay, 16'hfffd, "bypass newest y");
        chk(az, 16'h5a02, "bypass newest z");
        chk(16'(overrun), 16'h0001, "bypass overwrite");
        sleep_i = 1'b1;
        push_run(3, 1);
        sleep_i = 1'b0;
        chk(ax, 16'h0002, "sleep blocks");
        expq.push_back(2);
        drain(1);
        chk(16'(overrun), 16'h0000, "overrun cleared");
        $display("test bypass done");
        i_host_port_model.write_reg(8'h38, 8'h44);
        push_run(10, 34);
        status(8'h20, "fill holds 32");
        chk(16'(overrun), 16'h0001, "fill drop");
        for (int i = 10; i < 43; i++) expq.push_back(i);
        drain(1);
        push_run(99, 1);
        expq.push_back(99);
        status(8'h20, "fill resumes");
        drain(28);
        status(8'h04, "count four");
        chk(16'(watermark), 16'h0001, "watermark at depth");
        drain(1);
        status(8'h03, "count three");
        chk(16'(watermark), 16'h0000, "watermark below depth");
        drain(4);
        chk(16'(data_ready), 16'h0000, "output empty");
        $display("test fill done");
        i_host_port_model.write_reg(8'h38, 8'h84);
        push_run(200, 40);
        status(8'h20, "rolling full");
        chk(16'(watermark), 16'h0001, "rolling watermark");
        chk(16'(overrun), 16'h0001, "rolling overwrite");
        expq.push_back(200);
        for (int i = 208; i < 240; i++) expq.push_back(i);
        drain(33);
        $display("test rolling done");
        i_host_port_model.write_reg(8'h38, 8'he3);
        push_run(300, 10);
        status(8'h03, "pre-trigger depth");
        pulse(1'b0);
        chk(16'(capture), 16'h0000, "line one ignored");
        pulse(1'b1);
        status(8'h83, "trigger flag");
        push_run(400, 40);
        status(8'ha0, "post-trigger full");
        chk(16'(overrun), 16'h0001, "post-trigger drop");
        expq = '{300, 307, 308, 309};
        for (int i = 400; i < 429; i++) expq.push_back(i);
        drain(33);
        i_host_port_model.write_reg(8'h38, 8'hc3);
        chk(16'(capture), 16'h0000, "rearmed");
        pulse(1'b1);
        chk(16'(capture), 16'h0000, "line two ignored");
        pulse(1'b0);
        chk(16'(capture), 16'h0001, "line one selected");
        i_host_port_model.write_reg(8'h38, 8'h80);
        chk(16'(watermark), 16'h0001, "zero depth rewrite");
        $display("test trigger done");
        results();
    end
endmodule : accel_sample_fifo_tb

bind accel_sample_fifo accel_fifo_monitor i_accel_fifo_monitor (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sample_valid_i(sample_valid_i),
    .irq_line_a_event_i(irq_line_a_event_i), .irq_line_b_event_i(irq_line_b_event_i),
    .reg_req_i(reg_req_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .axis_x_out_o(axis_x_out_o), .axis_z_out_o(axis_z_out_o), .data_ready_o(data_ready_o),
    .watermark_o(watermark_o), .overrun_o(overrun_o),
    .capture_event_flag_o(capture_event_flag_o)
);
